// ===== bench/rss_breaker_model.sv
/*
 Behavioural breaker object control facing the shot sequencer.
 Assumes one-cycle open and close commands on ref_clk; the bench plays protection.
*/
`timescale 1ns/1ns
module rss_breaker_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic open_cmd,
   input wire logic close_cmd,
   input wire logic trip,
   input wire logic man_close,
   input wire logic slow,
   input wire logic fail,
   output logic breaker_open,
   output logic breaker_closed,
   output logic open_fail,
   output logic close_fail
);
   logic closed;       // Main contacts, no intermediate position
   logic [3:0] wait_n; // Close held back: not ready or sync pending
   assign breaker_closed = closed;
   assign breaker_open = ~closed;
   // Open on trip or command; close after a short or long wait, or fail
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         closed <= 1'b1;
         wait_n <= 4'h0;
         open_fail <= 1'b0;
         close_fail <= 1'b0;
      end else begin
         open_fail <= open_cmd & fail;
         close_fail <= 1'b0;
         if (trip || (open_cmd && !fail)) begin
            closed <= 1'b0;
         end
         if (man_close) begin
            closed <= 1'b1;
         end else if (close_cmd) begin
            wait_n <= slow ? 4'h8 : 4'h1;
         end else if (wait_n == 4'h1) begin
            // Failure is a time-out ack; breaker stays open
            wait_n <= 4'h0;
            closed <= ~fail;
            close_fail <= fail;
         end else if (wait_n != 4'h0) begin
            wait_n <= wait_n - 4'h1;
         end
      end
   end
endmodule

// ===== bench/rss_sequencer_tb_top.sv
/*
 Self-checking bench for the shot sequencer with a breaker model.
 Assumes the millisecond prescaler is cut to four cycles.
*/
`timescale 1ns/1ns
module rss_sequencer_tb_top;
   import rss_pkg::*;
   localparam int TICK = 4; // Short millisecond keeps the run brief
   logic ref_clk, rst, reg_wr, reg_rd, crit, lock_rst, trip, man_close, slow, fail;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
   logic [NUM_REQ-1:0] req;
   logic brk_open, brk_closed, open_fail, close_fail;
   logic open_cmd, close_cmd, final_trip, lockout, irq;
   int error_cnt, checked, cyc, close_n, dead_n, n, k0;

   rss_sequencer #(.TICK_CYCLES(TICK)) rss_sequencer_inst (.ref_clk(ref_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reclose_request(req), .critical_request(crit),
      .breaker_open(brk_open), .breaker_closed(brk_closed), .open_fail(open_fail),
      .close_fail(close_fail), .lock_reset_in(lock_rst), .open_cmd(open_cmd),
      .close_cmd(close_cmd), .final_trip(final_trip), .lockout(lockout), .irq(irq));
   rss_breaker_model rss_breaker_model_inst (.ref_clk(ref_clk), .rst(rst),
      .open_cmd(open_cmd), .close_cmd(close_cmd), .trip(trip), .man_close(man_close),
      .slow(slow), .fail(fail), .breaker_open(brk_open), .breaker_closed(brk_closed),
      .open_fail(open_fail), .close_fail(close_fail));

   // Free-running clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Hang limit, dead interval length and close command tally
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      dead_n <= brk_closed ? 0 : dead_n + 1;
      close_n <= close_n + int'(close_cmd);
      if (cyc == 40000) begin
         error_cnt++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // Data are sampled at the edge closing their only valid cycle
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      d = reg_rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(d, exp);
   endtask
   task automatic set_req(input logic [4:0] v);
      @(posedge ref_clk);
      req <= v;
   endtask
   // One-cycle pulses on bench-driven controls
   task automatic pulse(input int k);
      @(posedge ref_clk);
      if (k == 0) trip <= 1'b1;
      else if (k == 1) man_close <= 1'b1;
      else lock_rst <= 1'b1;
      @(posedge ref_clk);
      trip <= 1'b0;
      man_close <= 1'b0;
      lock_rst <= 1'b0;
   endtask
   function automatic logic pick(input int k);
      case (k)
         0: return close_cmd;
         1: return open_cmd;
         2: return lockout;
         default: return brk_open;
      endcase
   endfunction
   // Bounded wait; n ends as the number of cycles waited
   task automatic wait_hi(input int k);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pick(k) !== 1'b1 && n < 3000);
      chk(32'(n < 3000), 32'h0000_0001);
   endtask

   initial begin
      {reg_wr, reg_rd, crit, lock_rst, trip, man_close, slow, fail} = 8'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      req = 5'h00;
      rst = 1'b1;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      // Reset values, an unmapped place, mask read-back
      rdc(ADDR_CTRL, 32'h0000_0000);
      rdc(ADDR_STATUS, 32'h0000_0000);
      rdc(ADDR_ARC, 32'h0000_00C8);
      rdc(ADDR_RECLAIM, 32'h0000_2710);
      for (int i = 0; i < NUM_REQ; i++) rdc(ADDR_REQ_BASE + 8'(4 * i), REQ_CFG_RESET);
      rdc(8'h3C, 32'h0000_0000);
      wr(ADDR_IRQ_MASK, 32'h0000_001F);
      rdc(ADDR_IRQ_MASK, 32'h0000_001F);
      $display("test registers done");
      // Three ms dead time, shots 0..2, short arc and reclaim
      wr(ADDR_ARC, 32'h0000_0002);
      wr(ADDR_RECLAIM, 32'h0000_000A);
      for (int i = 0; i < NUM_REQ; i++) wr(ADDR_REQ_BASE + 8'(4 * i), 32'h0003_0007);
      wr(ADDR_CTRL, 32'h0000_0001);
      // Two requests together, a higher one joins in the dead interval
      set_req(5'h14);
      rd(ADDR_STATUS);
      chk(32'(d[10:0]), 32'h0000_0202);
      pulse(0);
      wait_hi(3);
      set_req(5'h15);
      rd(ADDR_STATUS);
      chk(32'(d[10:8]), 32'h0000_0000);
      wait_hi(0);
      chk(32'(dead_n >= 3 * TICK && dead_n <= 3 * TICK + 8), 32'h0000_0001);
      req <= 5'h00;
      repeat (70) @(posedge ref_clk);
      rd(ADDR_STATUS);
      chk(32'(d[3:0]), 32'(ST_IDLE));
      rdc(ADDR_IRQ_STAT, 32'h0000_0001);
      chk(32'(irq), 32'h0000_0001);
      wr(ADDR_IRQ_STAT, 32'h0000_001F);
      @(posedge ref_clk);
      chk(32'(irq), 32'h0000_0000);
      $display("test single shot done");
      // Persisting fault, then a reappearance with rearming off
      set_req(5'h02);
      pulse(0);
      wait_hi(0);
      repeat (4) @(posedge ref_clk);
      pulse(0);
      rd(ADDR_STATUS);
      chk(32'(d[6:4]), 32'h0000_0001);
      wait_hi(0);
      req <= 5'h00;
      repeat (4) @(posedge ref_clk);
      req <= 5'h02;
      wait_hi(1);
      rd(ADDR_STATUS);
      chk(32'(d[13:12]), 32'h0000_0003);
      k0 = close_n;
      repeat (20) @(posedge ref_clk);
      chk(32'(close_n - k0), 32'h0000_0000);
      wr(ADDR_IRQ_MASK, 32'h0000_0000);
      @(posedge ref_clk);
      chk(32'(irq), 32'h0000_0000);
      rdc(ADDR_IRQ_STAT, 32'h0000_0007);
      wr(ADDR_IRQ_MASK, 32'h0000_001F);
      @(posedge ref_clk);
      chk(32'(irq), 32'h0000_0001);
      wr(ADDR_IRQ_STAT, 32'h0000_001F);
      set_req(5'h00);
      wr(ADDR_CTRL, 32'h0000_0101);
      @(posedge ref_clk);
      chk(32'(lockout), 32'h0000_0000);
      pulse(1);
      $display("test final trip done");
      // Critical request in the dead interval; held critical keeps the lock
      set_req(5'h01);
      pulse(0);
      wait_hi(3);
      crit <= 1'b1;
      k0 = close_n;
      @(posedge ref_clk);
      @(posedge ref_clk);
      chk(32'(lockout), 32'h0000_0001);
      pulse(2);
      @(posedge ref_clk);
      chk(32'(lockout), 32'h0000_0001);
      rd(ADDR_IRQ_STAT);
      chk(32'(d[IRQ_CRIT]), 32'h0000_0001);
      wr(ADDR_IRQ_STAT, 32'h0000_001F);
      set_req(5'h00);
      crit <= 1'b0;
      pulse(2);
      @(posedge ref_clk);
      chk(32'(lockout), 32'h0000_0000);
      chk(32'(close_n - k0), 32'h0000_0000);
      pulse(1);
      $display("test critical done");
      // Slow close ending in a failure ack, cleared by closing
      @(posedge ref_clk);
      slow <= 1'b1;
      fail <= 1'b1;
      set_req(5'h01);
      pulse(0);
      wait_hi(0);
      repeat (3) @(posedge ref_clk);
      rd(ADDR_STATUS);
      chk(32'(d[3:0]), 32'(ST_CLOSE_WAIT));
      wait_hi(2);
      rd(ADDR_STATUS);
      chk(32'(d[ST_FAIL]), 32'h0000_0001);
      set_req(5'h00);
      slow <= 1'b0;
      fail <= 1'b0;
      pulse(1);
      repeat (2) @(posedge ref_clk);
      chk(32'(lockout), 32'h0000_0000);
      $display("test close failure done");
      // Fixed arcing delay before opening; a reappearing fault rearms
      wr(ADDR_CTRL, 32'h0000_0007);
      set_req(5'h01);
      wait_hi(1);
      chk(32'(n >= 2 * TICK && n <= 2 * TICK + 8), 32'h0000_0001);
      req <= 5'h00;
      wait_hi(0);
      repeat (4) @(posedge ref_clk);
      req <= 5'h01;
      wait_hi(1);
      rd(ADDR_STATUS);
      chk(32'(d[12:4]), 32'h0000_0001);
      req <= 5'h00;
      wait_hi(0);
      repeat (70) @(posedge ref_clk);
      // Forced final trip on the first request
      wr(ADDR_CTRL, 32'h0000_0009);
      set_req(5'h01);
      wait_hi(2);
      chk(32'(final_trip), 32'h0000_0001);
      set_req(5'h00);
      wr(ADDR_CTRL, 32'h0000_0100);
      @(posedge ref_clk);
      chk(32'(lockout), 32'h0000_0000);
      $display("test arcing and forced final done");
      finish_test();
   end
endmodule

// ===== verilog/rss_pkg.sv
/*
 Constants, register map, state type and shared decode for the auto-reclose
 shot sequencer. Assumes a 100 MHz system clock and a plain strobe register port.
// Operation
// - Close breaker after full dead time, line open
// - Persisting fault proceeds to next enabled shot
// - Final trip when configured or shots exhausted
// - Select fixed arcing delay or protection timing
// - Reappearing fault: rearm next shot or final trip
// - Five reclose requests, first ranks highest
// - Critical request halts sequence into lock-out
// - Unclearable fault stays locked until explicit reset
// - Higher-priority request takes over shot settings
// - Command failure locks; reset input or closed clears
// - Close waits for object success or failure
*/
package rss_pkg;
   localparam int NUM_REQ = 5;   // Prioritised reclose request inputs
   localparam int NUM_SHOT = 5;  // Shots per request
   localparam int TIME_W = 16;   // Interval width, in milliseconds
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_ARC = 8'h10;
   localparam logic [7:0] ADDR_RECLAIM = 8'h14;
   localparam logic [7:0] ADDR_REQ_BASE = 8'h20;
   localparam logic [7:0] ADDR_REQ_END = 8'h34;
   // Control fields
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_FIXED_ARC = 1;
   localparam int CTRL_REARM = 2;
   localparam int CTRL_FORCE_FINAL = 3;
   localparam int CTRL_LOCK_CLR = 8;
   // Status fields
   localparam int ST_SHOT_LSB = 4;
   localparam int ST_REQ_LSB = 8;
   localparam int ST_LOCK = 12;
   localparam int ST_FINAL = 13;
   localparam int ST_FAIL = 14;
   // Interrupt bits
   localparam int IRQ_RECLOSE = 0;
   localparam int IRQ_FINAL = 1;
   localparam int IRQ_LOCK = 2;
   localparam int IRQ_CRIT = 3;
   localparam int IRQ_FAIL = 4;
   localparam int IRQ_W = 5;
   // Per-request config: shot enables low, dead time high
   localparam int REQ_DEAD_LSB = 16;
   // Reset values
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [TIME_W-1:0] ARC_RESET = 16'h00C8;
   localparam logic [TIME_W-1:0] RECLAIM_RESET = 16'h2710;
   localparam logic [31:0] REQ_CFG_RESET = 32'h00C8_0001;
   // Time base
   localparam int TIME_UNIT_NS = 1000000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_CYCLES_DFLT = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] NO_SHOT = 3'h5;  // Marks no enabled shot left

   typedef enum logic [3:0] {
      ST_IDLE, ST_ARC, ST_WAIT_OPEN, ST_DEAD, ST_CLOSE_WAIT, ST_RECLAIM, ST_FINALTRIP,
      ST_LOCKOUT
   } rss_state_t;

   // Lowest set index at or above from; NO_SHOT when none
   function automatic logic [2:0] rss_first_set(input logic [4:0] v, input logic [2:0] from);
      logic [2:0] r;
      r = NO_SHOT;
      for (int i = NUM_SHOT - 1; i >= 0; i--) begin
         if (v[i] && (i >= int'(from))) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction
endpackage

// ===== verilog/rss_prio_arb.sv
/*
 Fixed-priority arbiter over the reclose requests; bit 0 ranks highest.
 Assumes requests are synchronous levels.
*/
`timescale 1ns/1ns
module rss_prio_arb #(
   parameter int N = rss_pkg::NUM_REQ
) (
   input wire logic [N-1:0] req,
   output logic any,
   output logic [2:0] idx
);
   import rss_pkg::*;
   // Shared decode serves exactly NUM_REQ requests
   if (N != NUM_REQ) begin : g_bad_n
      $error("rss_prio_arb: N must equal NUM_REQ");
   end
   // Lowest index wins, so simultaneous requests resolve to the top one
   assign idx = rss_first_set(req, 3'h0);
   assign any = |req;
endmodule

// ===== verilog/rss_sequencer.sv
/*
 Auto-reclose shot sequencer: register port, arbitration, interval timing,
 shot sequencing, lock-out and interrupt. Assumes synchronous inputs and a
 breaker object-control block that acknowledges close success or failure.
*/
`timescale 1ns/1ns
module rss_sequencer #(
   parameter int TICK_CYCLES = rss_pkg::TICK_CYCLES_DFLT
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [rss_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [rss_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [rss_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [rss_pkg::NUM_REQ-1:0] reclose_request,
   input wire logic critical_request,
   input wire logic breaker_open,
   input wire logic breaker_closed,
   input wire logic open_fail,
   input wire logic close_fail,
   input wire logic lock_reset_in,
   output logic open_cmd,
   output logic close_cmd,
   output logic final_trip,
   output logic lockout,
   output logic irq
);
   import rss_pkg::*;

   rss_state_t state, next_state;       // Sequence position
   logic [3:0] ctrl;                    // Enable, fixed arc, rearm, force final
   logic [TIME_W-1:0] arc_time;         // Fixed arcing delay, ms
   logic [TIME_W-1:0] reclaim_time;     // Reclaim interval, ms
   logic [DATA_W-1:0] req_cfg [NUM_REQ];
   logic [IRQ_W-1:0] irq_stat, irq_mask;
   logic [2:0] shot, next_shot;         // Current shot index
   logic [2:0] active_req, next_req;    // Request whose settings apply
   logic fail_lock;                     // Lock-out caused by command failure
   logic fault_cleared;                 // Request dropped since reclose
   logic crit_d;

   rss_timer_if tif ();
   rss_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .t(tif.tmr)
   );

   wire req_any;
   wire [2:0] req_idx;
   rss_prio_arb #(.N(NUM_REQ)) u_arb (
      .req(reclose_request),
      .any(req_any),
      .idx(req_idx)
   );

   // Register decode
   wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
   wire wr_stat = reg_wr && (reg_addr == ADDR_IRQ_STAT);
   wire wr_mask = reg_wr && (reg_addr == ADDR_IRQ_MASK);
   wire wr_arc = reg_wr && (reg_addr == ADDR_ARC);
   wire wr_recl = reg_wr && (reg_addr == ADDR_RECLAIM);
   wire req_hit = (reg_addr >= ADDR_REQ_BASE) && (reg_addr < ADDR_REQ_END)
                  && (reg_addr[1:0] == 2'b00);
   wire [7:0] req_off = reg_addr - ADDR_REQ_BASE;
   wire [2:0] req_sel = req_off[4:2];

   // Configuration views
   wire cfg_enable = ctrl[CTRL_ENABLE];
   wire cfg_fixed_arc = ctrl[CTRL_FIXED_ARC];
   wire cfg_rearm = ctrl[CTRL_REARM];
   wire cfg_force_final = ctrl[CTRL_FORCE_FINAL];
   wire lock_clear = lock_reset_in || (wr_ctrl && reg_wdata[CTRL_LOCK_CLR]);
   wire cmd_fail = open_fail || close_fail;
   wire [4:0] act_mask = req_cfg[active_req][NUM_SHOT-1:0];
   wire [4:0] new_mask = req_cfg[req_idx][NUM_SHOT-1:0];
   wire [TIME_W-1:0] act_dead = req_cfg[active_req][REQ_DEAD_LSB +: TIME_W];
   wire [2:0] first_shot = rss_first_set(new_mask, 3'h0);
   wire [2:0] later_shot = rss_first_set(act_mask, shot + 3'h1);
   wire seq_active = (state == ST_ARC) || (state == ST_WAIT_OPEN) || (state == ST_DEAD)
                     || (state == ST_CLOSE_WAIT) || (state == ST_RECLAIM);
   // Arcing delay only when configured; otherwise protection opens the breaker
   wire [3:0] open_path = cfg_fixed_arc ? 4'(ST_ARC) : 4'(ST_WAIT_OPEN);

   // Next state
   always_comb begin
      next_state = state;
      next_shot = shot;
      next_req = active_req;
      if (critical_request) begin
         next_state = ST_LOCKOUT;
      end else if (cmd_fail) begin
         next_state = ST_LOCKOUT;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (cfg_enable && req_any && breaker_closed) begin
                  next_req = req_idx;
                  next_shot = first_shot;
                  if (cfg_force_final || (first_shot == NO_SHOT)) begin
                     next_state = ST_FINALTRIP;
                  end else begin
                     next_state = rss_state_t'(open_path);
                  end
               end
            end
            ST_ARC: begin
               if (tif.done) begin
                  next_state = ST_WAIT_OPEN;
               end
            end
            ST_WAIT_OPEN: begin
               if (breaker_open) begin
                  next_state = ST_DEAD;
               end
            end
            ST_DEAD: begin
               // Dead time counts only with the line de-energised
               if (!breaker_open) begin
                  next_state = ST_WAIT_OPEN;
               end else if (tif.done) begin
                  next_state = ST_CLOSE_WAIT;
               end
            end
            ST_CLOSE_WAIT: begin
               // No own time-out: object control reports failure
               if (breaker_closed) begin
                  next_state = ST_RECLAIM;
               end
            end
            ST_RECLAIM: begin
               if (req_any) begin
                  if ((later_shot != NO_SHOT) && (!fault_cleared || cfg_rearm)) begin
                     next_shot = later_shot;
                     next_state = rss_state_t'(open_path);
                  end else begin
                     next_state = ST_FINALTRIP;
                  end
               end else if (tif.done) begin
                  next_state = ST_IDLE;
               end
            end
            ST_FINALTRIP: begin
               next_state = ST_LOCKOUT;
            end
            ST_LOCKOUT: begin
               // Failure lock-out also clears on a closed breaker
               if (lock_clear || (fail_lock && breaker_closed)) begin
                  next_state = ST_IDLE;
               end
            end
         endcase
         // An evolving fault moves to the higher-priority settings
         if (seq_active && req_any && (req_idx < active_req)) begin
            next_req = req_idx;
         end
      end
   end

   // Timer control
   wire entering = (next_state != state);
   assign tif.start = entering && ((next_state == ST_ARC) || (next_state == ST_DEAD)
                      || (next_state == ST_RECLAIM));
   assign tif.load = (next_state == ST_ARC) ? arc_time :
                     (next_state == ST_DEAD) ? act_dead : reclaim_time;

   // Events
   wire go_open = ((state == ST_ARC) && (next_state == ST_WAIT_OPEN)) || (state == ST_FINALTRIP);
   wire go_close = (state == ST_DEAD) && (next_state == ST_CLOSE_WAIT);
   wire go_lock = (next_state == ST_LOCKOUT) && (state != ST_LOCKOUT);
   wire [IRQ_W-1:0] events = {cmd_fail, critical_request && !crit_d, go_lock,
                              state == ST_FINALTRIP, go_close};

   // Sequence registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         shot <= '0;
         active_req <= '0;
         crit_d <= 1'b0;
      end else begin
         state <= next_state;
         shot <= next_shot;
         active_req <= next_req;
         crit_d <= critical_request;
      end
   end

   // Command pulses and lock indications
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         open_cmd <= 1'b0;
         close_cmd <= 1'b0;
         lockout <= 1'b0;
         final_trip <= 1'b0;
         fail_lock <= 1'b0;
      end else begin
         open_cmd <= go_open;
         close_cmd <= go_close;
         lockout <= (next_state == ST_LOCKOUT);
         final_trip <= (next_state == ST_FINALTRIP) || (next_state == ST_LOCKOUT && final_trip);
         if (next_state != ST_LOCKOUT) begin
            fail_lock <= 1'b0;
         end else if (cmd_fail && !critical_request) begin
            fail_lock <= 1'b1;
         end
      end
   end

   // Discrimination: note whether the fault dropped after reclosing
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fault_cleared <= 1'b0;
      end else if (state != ST_RECLAIM) begin
         fault_cleared <= 1'b0;
      end else if (!req_any) begin
         fault_cleared <= 1'b1;
      end
   end

   // Configuration writes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
         arc_time <= ARC_RESET;
         reclaim_time <= RECLAIM_RESET;
         irq_mask <= '0;
         for (int i = 0; i < NUM_REQ; i++) begin
            req_cfg[i] <= REQ_CFG_RESET;
         end
      end else begin
         if (wr_ctrl) ctrl <= reg_wdata[3:0];
         if (wr_arc) arc_time <= reg_wdata[TIME_W-1:0];
         if (wr_recl) reclaim_time <= reg_wdata[TIME_W-1:0];
         if (wr_mask) irq_mask <= reg_wdata[IRQ_W-1:0];
         if (reg_wr && req_hit) req_cfg[req_sel] <= reg_wdata;
      end
   end

   // Sticky status; a new event wins over a write-one clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~(wr_stat ? reg_wdata[IRQ_W-1:0] : '0)) | events;
      end
   end
   assign irq = |(irq_stat & irq_mask);

   // Read mux; unmapped addresses read zero
   wire [DATA_W-1:0] status_word = DATA_W'({fail_lock, final_trip, lockout, 1'b0,
                                    active_req, 1'b0, shot, 4'(state)});
   wire [DATA_W-1:0] rd_mux =
      (reg_addr == ADDR_CTRL) ? DATA_W'(ctrl) :
      (reg_addr == ADDR_STATUS) ? status_word :
      (reg_addr == ADDR_IRQ_STAT) ? DATA_W'(irq_stat) :
      (reg_addr == ADDR_IRQ_MASK) ? DATA_W'(irq_mask) :
      (reg_addr == ADDR_ARC) ? DATA_W'(arc_time) :
      (reg_addr == ADDR_RECLAIM) ? DATA_W'(reclaim_time) :
      req_hit ? req_cfg[req_sel] : '0;

   // Read data valid the cycle after the strobe only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : '0;
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   crit_lock_a: assert property (critical_request |=> state == ST_LOCKOUT && lockout)
      else $error("critical request did not lock");
   close_after_dead_a: assert property (close_cmd |-> $past(state) == ST_DEAD
      && $past(tif.done) && $past(breaker_open)) else $error("close before dead time");
   lock_no_close_a: assert property (lockout |-> !close_cmd)
      else $error("close issued in lock-out");
   final_open_a: assert property (state == ST_FINALTRIP |=> open_cmd && final_trip
      && state == ST_LOCKOUT) else $error("final trip sequence wrong");
   fail_lock_a: assert property (cmd_fail && !critical_request |=> lockout && fail_lock)
      else $error("command failure did not lock");
   top_wins_a: assert property (reclose_request[0] |-> req_idx == 3'h0)
      else $error("top request not selected");
   start_prio_a: assert property (state == ST_IDLE && next_state != ST_IDLE
      && !critical_request && !cmd_fail |=> active_req == $past(req_idx))
      else $error("sequence started on wrong request");
   evolve_a: assert property (seq_active && req_any && req_idx < active_req
      && !critical_request && !cmd_fail |=> active_req == $past(req_idx))
      else $error("higher request not taken over");
   close_hold_a: assert property (state == ST_CLOSE_WAIT && !breaker_closed
      && !cmd_fail && !critical_request |=> state == ST_CLOSE_WAIT)
      else $error("close wait left early");
   reappear_a: assert property (state == ST_RECLAIM && req_any && fault_cleared
      && !cfg_rearm && !cmd_fail && !critical_request |=> state == ST_FINALTRIP)
      else $error("reappearing fault not final-tripped");
   arc_mode_a: assert property (state == ST_ARC && $past(state) != ST_ARC
      |-> $past(cfg_fixed_arc)) else $error("arcing delay without fixed mode");

   reclose_ok_c: cover property (state == ST_RECLAIM ##1 state == ST_IDLE);
   second_shot_c: cover property (state == ST_RECLAIM ##1 state != ST_RECLAIM
      && state != ST_IDLE && state != ST_FINALTRIP && state != ST_LOCKOUT);
   final_c: cover property (state == ST_FINALTRIP);
   crit_c: cover property (seq_active && critical_request);
endmodule

// ===== verilog/rss_timer.sv
/*
 Millisecond interval timer with its own prescaler.
 Assumes start is a one-cycle pulse; a new start restarts the interval.
*/
`timescale 1ns/1ns
module rss_timer #(
   parameter int TICK_CYCLES = rss_pkg::TICK_CYCLES_DFLT
) (
   input wire logic ref_clk,
   input wire logic rst,
   rss_timer_if.tmr t
);
   import rss_pkg::*;
   // Refuse a prescaler that could never wrap
   if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("rss_timer: TICK_CYCLES must be at least one");
   end
   logic [31:0] pre;           // Cycles within the current millisecond
   logic [TIME_W-1:0] cnt;     // Milliseconds left
   logic run;                  // Interval in progress
   logic done_q;
   wire tick = (pre == 32'(TICK_CYCLES - 1));
   wire expire = run && (cnt == '0) && !t.start;
   assign t.done = done_q;

   // Restart on start; count down one ms per prescaler wrap
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pre <= '0;
         cnt <= '0;
         run <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= expire;
         if (t.start) begin
            pre <= '0;
            cnt <= t.load;
            run <= 1'b1;
         end else if (expire) begin
            run <= 1'b0;
         end else if (run) begin
            pre <= tick ? '0 : pre + 32'h0000_0001;
            if (tick) begin
               cnt <= cnt - 16'h0001;
            end
         end
      end
   end
endmodule

// ===== verilog/rss_timer_if.sv
/*
 Carrier between the sequencer and its interval timer.
 Assumes both ends share ref_clk.
*/
`timescale 1ns/1ns
interface rss_timer_if;
   import rss_pkg::*;
   logic start;               // One-cycle load pulse
   logic [TIME_W-1:0] load;   // Interval in milliseconds
   logic done;                // One-cycle expiry pulse
   modport ctl (output start, output load, input done);
   modport tmr (input start, input load, output done);
endinterface
